// *** include/dbm_pkg.sv ***
// ****************************************************************
// Shared constants for the DMA bus-master signalling block
// ****************************************************************
package dbm_pkg;

  // Bus and channel geometry
  localparam int DBM_CHANNELS   = 4;
  localparam int DBM_CH_W       = 2;
  localparam int DBM_ADDR_W     = 16;
  localparam int DBM_DATA_W     = 8;
  localparam int DBM_NIB_W      = 4;
  localparam int DBM_FIFO_DEPTH = 8;

  // Address field positions
  localparam int DBM_LOW_NIB_LSB = 0;
  localparam int DBM_UP_NIB_LSB  = 4;
  localparam int DBM_HI_BYTE_LSB = 8;

  // Event record: {channel, address, terminal}
  localparam int DBM_EVT_W = DBM_CH_W + DBM_ADDR_W + 1;

  // Counter constants and reset values
  localparam logic [DBM_ADDR_W-1:0] DBM_ADDR_RESET  = 16'h0000;
  localparam logic [DBM_ADDR_W-1:0] DBM_COUNT_RESET = 16'h0000;
  localparam logic [DBM_ADDR_W-1:0] DBM_STEP        = 16'h0001;
  localparam logic [DBM_ADDR_W-1:0] DBM_COUNT_LAST  = 16'h0000;
  localparam logic [DBM_DATA_W-1:0] DBM_BYTE_RESET  = 8'h00;

  // Fixed channel roles in memory-to-memory moves
  localparam logic [DBM_CH_W-1:0] DBM_SRC_CH = 2'h0;
  localparam logic [DBM_CH_W-1:0] DBM_DST_CH = 2'h1;

  // Engine states, one clock period each except idle and hold-wait
  typedef enum logic [3:0] {
    DBM_ST_IDLE  = 4'h0,
    DBM_ST_HOLD  = 4'h1,
    DBM_ST_ADDR  = 4'h2,
    DBM_ST_XFR2  = 4'h3,
    DBM_ST_XFR3  = 4'h4,
    DBM_ST_XFR4  = 4'h5,
    DBM_ST_MRD1  = 4'h6,
    DBM_ST_MRD2  = 4'h7,
    DBM_ST_MRD3  = 4'h8,
    DBM_ST_MRD4  = 4'h9,
    DBM_ST_MWR1  = 4'ha,
    DBM_ST_MWR2  = 4'hb,
    DBM_ST_MWR3  = 4'hc,
    DBM_ST_MWR4  = 4'hd
  } dbm_state_t;

  // Service modes
  typedef enum logic [1:0] {
    DBM_MODE_SINGLE = 2'h0,
    DBM_MODE_DEMAND = 2'h1,
    DBM_MODE_BLOCK  = 2'h2
  } dbm_mode_t;

endpackage

// *** design/dbm_top.sv ***
// Behaviour
// - Upper nibble driven only during service
// - Hold request on unmasked or software request
// - No bus drive before hold grant
// - Loopback use: exactly one hold-wait state
// - Acknowledge polarity selectable, high after reset
// - Address enable high during transfers
// - Strobe upper byte when it changes; memory copy strobes it every half
// - Address strobe timed from falling edge
// - Read strobe low for reads, source half
// - Write strobe low for writes, destination half
// - I/O transfers never capture the data byte
// - Memory copy keeps byte in temporary store
// - Memory copy byte takes over twice longer
// - Fill mode repeats one fixed source byte
// - Single and demand modes run without software
// - Priority encoder picks one winner
// - Upper address byte output on data lines
// - Low nibble address driven in active cycle
// - Channel 0 highest, channel 3 lowest
`timescale 1ns/1ps

// ****************************************************************
// Shift-register FIFO, every output straight from a flop
// ****************************************************************
module dbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_sync_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] wr_idx;
  logic             push;
  logic             pop;

  // Full and empty come from the entry valid flags
  assign in_ready  = ~vld_reg[DEPTH-1];
  assign out_valid = vld_reg[0];
  assign out_data  = mem_reg[0];
  assign push      = in_valid & ~vld_reg[DEPTH-1];
  assign pop       = vld_reg[0] & out_ready;
  assign wr_idx    = pop ? count_reg - CNT_W'(1) : count_reg;

  // Occupancy count
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_reg <= '0;
    end else if (ce) begin
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // Each entry loads new data or takes its upper neighbour on a pop
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        mem_reg[i] <= '0;
        vld_reg[i] <= 1'b0;
      end else if (ce) begin
        if (push && wr_idx == CNT_W'(i)) begin
          mem_reg[i] <= in_data;
          vld_reg[i] <= 1'b1;
        end else if (pop) begin
          if (i == DEPTH - 1) begin
            mem_reg[i] <= '0;
            vld_reg[i] <= 1'b0;
          end else begin
            mem_reg[i] <= mem_reg[(i + 1) % DEPTH];
            vld_reg[i] <= vld_reg[(i + 1) % DEPTH];
          end
        end
      end
    end
  end
endmodule // dbm_fifo

// ****************************************************************
// Bus-master engine
// ****************************************************************
module dbm_top
  import dbm_pkg::*;
#(
  parameter int FIFO_DEPTH = DBM_FIFO_DEPTH
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic [DBM_CHANNELS-1:0] channel_request,
  input  wire logic [DBM_CHANNELS-1:0] channel_mask,
  input  wire logic [DBM_CHANNELS-1:0] sw_request,
  input  wire logic [1:0]              xfer_mode,
  input  wire logic                    write_xfer,
  input  wire logic                    mem_to_mem_en,
  input  wire logic                    fill_en,
  input  wire logic                    ack_active_high,
  input  wire logic                    standalone_en,
  input  wire logic                    cfg_load,
  input  wire logic [DBM_CH_W-1:0]     cfg_channel,
  input  wire logic [DBM_ADDR_W-1:0]   cfg_addr,
  input  wire logic [DBM_ADDR_W-1:0]   cfg_count,
  input  wire logic                    bus_hold_grant,
  output logic                         bus_hold_request,
  output logic [DBM_NIB_W-1:0]         upper_nibble_address,
  output logic                         upper_nibble_address_oe,
  output logic [DBM_NIB_W-1:0]         low_nibble_address,
  output logic                         low_nibble_address_oe,
  input  wire logic [DBM_DATA_W-1:0]   data_lines_in,
  output logic [DBM_DATA_W-1:0]        data_lines_out,
  output logic                         data_lines_oe,
  output logic                         upper_address_enable,
  output logic                         upper_address_strobe,
  output logic                         memory_read_strobe_n,
  output logic                         memory_read_strobe_oe,
  output logic                         memory_write_strobe_n,
  output logic                         memory_write_strobe_oe,
  output logic [DBM_CHANNELS-1:0]      channel_acknowledge,
  output logic                         evt_valid,
  output logic [DBM_EVT_W-1:0]         evt_data,
  input  wire logic                    evt_ready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                    rst_meta_reg, rst_sync_n;
  logic [DBM_CHANNELS-1:0] req_meta_reg, req_sync_reg;
  logic                    grant_meta_reg, grant_sync_reg;
  logic [DBM_DATA_W-1:0]   data_meta_reg, data_sync_reg;
  dbm_state_t              state_reg, state_next;
  logic [DBM_CH_W-1:0]     act_ch_reg;
  logic                    m2m_reg;
  logic [DBM_ADDR_W-1:0]   addr_reg [DBM_CHANNELS];
  logic [DBM_ADDR_W-1:0]   count_reg [DBM_CHANNELS];
  logic [DBM_DATA_W-1:0]   temp_byte_reg;
  logic [DBM_CHANNELS-1:0] pending;
  logic                    evt_in_ready, evt_push;
  logic [DBM_EVT_W-1:0]    evt_record;
  logic [DBM_CH_W-1:0]     work_ch;
  logic [DBM_ADDR_W-1:0]   work_addr;
  logic                    working, io_last, keep_going;
  localparam int EVT_LVL_W = $clog2(FIFO_DEPTH + 1);
  logic                    start_ok, evt_room_next;
  logic [EVT_LVL_W-1:0]    evt_level_reg;

  // Fixed priority: lowest channel number wins
  function automatic logic [DBM_CH_W-1:0] pick_channel(input logic [DBM_CHANNELS-1:0] vec);
    pick_channel = '0;
    for (int i = DBM_CHANNELS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        pick_channel = DBM_CH_W'(i);
      end
    end
  endfunction

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  // Reset asserts at once but releases through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // Pins from outside the clock domain pass two flops
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_meta_reg   <= '0;
      req_sync_reg   <= '0;
      grant_meta_reg <= 1'b0;
      grant_sync_reg <= 1'b0;
      data_meta_reg  <= '0;
      data_sync_reg  <= '0;
    end else if (ce) begin
      req_meta_reg   <= channel_request;
      req_sync_reg   <= req_meta_reg;
      grant_meta_reg <= bus_hold_grant;
      grant_sync_reg <= grant_meta_reg;
      data_meta_reg  <= data_lines_in;
      data_sync_reg  <= data_meta_reg;
    end
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  assign pending    = (req_sync_reg & ~channel_mask) | sw_request;
  assign io_last    = count_reg[act_ch_reg] == DBM_COUNT_LAST;
  // A stale grant from the last service must drop before a new request
  assign start_ok   = |pending && evt_in_ready && (standalone_en || !grant_sync_reg);
  // Demand mode relies on the peripheral holding its request
  assign keep_going = (xfer_mode == DBM_MODE_BLOCK) ||
                      (xfer_mode == DBM_MODE_DEMAND && pending[act_ch_reg]);

  // Next state; a full event FIFO stalls the start of the next byte
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DBM_ST_IDLE: begin
        if (start_ok) begin
          state_next = DBM_ST_HOLD;
        end
      end
      DBM_ST_HOLD: begin
        if (standalone_en || grant_sync_reg) begin
          state_next = mem_to_mem_en ? DBM_ST_MRD1 : DBM_ST_ADDR;
        end
      end
      DBM_ST_ADDR: state_next = DBM_ST_XFR2;
      DBM_ST_XFR2: state_next = DBM_ST_XFR3;
      DBM_ST_XFR3: state_next = DBM_ST_XFR4;
      DBM_ST_XFR4: begin
        if (io_last || !keep_going || !evt_room_next) begin
          state_next = DBM_ST_IDLE;
        end else if ((addr_reg[act_ch_reg] + DBM_STEP) >> DBM_HI_BYTE_LSB !=
                     addr_reg[act_ch_reg] >> DBM_HI_BYTE_LSB) begin
          state_next = DBM_ST_ADDR;
        end else begin
          state_next = DBM_ST_XFR2;
        end
      end
      DBM_ST_MRD1: state_next = DBM_ST_MRD2;
      DBM_ST_MRD2: state_next = DBM_ST_MRD3;
      DBM_ST_MRD3: state_next = DBM_ST_MRD4;
      DBM_ST_MRD4: state_next = DBM_ST_MWR1;
      DBM_ST_MWR1: state_next = DBM_ST_MWR2;
      DBM_ST_MWR2: state_next = DBM_ST_MWR3;
      DBM_ST_MWR3: state_next = DBM_ST_MWR4;
      DBM_ST_MWR4: begin
        if (count_reg[DBM_DST_CH] == DBM_COUNT_LAST || xfer_mode == DBM_MODE_SINGLE ||
            !evt_room_next) begin
          state_next = DBM_ST_IDLE;
        end else begin
          state_next = DBM_ST_MRD1;
        end
      end
      default: state_next = DBM_ST_IDLE;
    endcase
  end

  // State, winning channel and service kind
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg  <= DBM_ST_IDLE;
      act_ch_reg <= '0;
      m2m_reg    <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      if (state_reg == DBM_ST_IDLE && state_next == DBM_ST_HOLD) begin
        act_ch_reg <= pick_channel(pending);
        m2m_reg    <= mem_to_mem_en;
      end
    end
  end

  // ****************************************************************
  // Address and count per channel
  // ****************************************************************
  for (genvar c = 0; c < DBM_CHANNELS; c++) begin : g_chan
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        addr_reg[c]  <= DBM_ADDR_RESET;
        count_reg[c] <= DBM_COUNT_RESET;
      end else if (ce) begin
        if (cfg_load && cfg_channel == DBM_CH_W'(c)) begin
          addr_reg[c]  <= cfg_addr;
          count_reg[c] <= cfg_count;
        end else if ((state_reg == DBM_ST_XFR4 && act_ch_reg == DBM_CH_W'(c)) ||
                     (state_reg == DBM_ST_MWR4 && DBM_DST_CH == DBM_CH_W'(c))) begin
          addr_reg[c]  <= addr_reg[c] + DBM_STEP;
          count_reg[c] <= count_reg[c] - DBM_STEP;
        end else if (state_reg == DBM_ST_MRD4 && DBM_SRC_CH == DBM_CH_W'(c)) begin
          // Fill holds the source still so one byte spreads over a block
          if (!fill_en) begin
            addr_reg[c] <= addr_reg[c] + DBM_STEP;
          end
          count_reg[c] <= count_reg[c] - DBM_STEP;
        end
      end
    end
  end

  // Only the memory-copy loads the store; the pin synchroniser adds two cycles
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      temp_byte_reg <= DBM_BYTE_RESET;
    end else if (ce && state_reg == DBM_ST_MWR1) begin
      temp_byte_reg <= data_sync_reg;
    end
  end

  // ****************************************************************
  // Bus outputs, one cycle behind the state; address strobe half a cycle
  // ****************************************************************
  assign working   = state_reg != DBM_ST_IDLE && state_reg != DBM_ST_HOLD;
  assign work_ch   = !m2m_reg ? act_ch_reg :
                     (state_reg inside {[DBM_ST_MRD1:DBM_ST_MRD4]}) ? DBM_SRC_CH : DBM_DST_CH;
  assign work_addr = addr_reg[work_ch];

  // Address, enable and strobes; all float back at idle
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_hold_request        <= 1'b0;
      upper_address_enable    <= 1'b0;
      upper_nibble_address    <= '0;
      upper_nibble_address_oe <= 1'b0;
      low_nibble_address      <= '0;
      low_nibble_address_oe   <= 1'b0;
      memory_read_strobe_n    <= 1'b1;
      memory_read_strobe_oe   <= 1'b0;
      memory_write_strobe_n   <= 1'b1;
      memory_write_strobe_oe  <= 1'b0;
    end else if (ce) begin
      bus_hold_request        <= state_reg != DBM_ST_IDLE;
      upper_address_enable    <= working;
      upper_nibble_address    <= work_addr[DBM_UP_NIB_LSB +: DBM_NIB_W];
      upper_nibble_address_oe <= working;
      low_nibble_address      <= work_addr[DBM_LOW_NIB_LSB +: DBM_NIB_W];
      low_nibble_address_oe   <= working;
      memory_read_strobe_n    <= !((!m2m_reg && !write_xfer && state_reg inside {DBM_ST_XFR3, DBM_ST_XFR4}) ||
                                   state_reg inside {DBM_ST_MRD2, DBM_ST_MRD3});
      memory_read_strobe_oe   <= working;
      memory_write_strobe_n   <= !((!m2m_reg && write_xfer && state_reg inside {DBM_ST_XFR3, DBM_ST_XFR4}) ||
                                   state_reg inside {DBM_ST_MWR3, DBM_ST_MWR4});
      memory_write_strobe_oe  <= working;
    end
  end

  // Data lines carry the upper byte, or the stored byte when writing it
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_lines_out <= '0;
      data_lines_oe  <= 1'b0;
    end else if (ce) begin
      if (state_reg inside {DBM_ST_ADDR, DBM_ST_MRD1, DBM_ST_MWR1}) begin
        data_lines_out <= work_addr[DBM_HI_BYTE_LSB +: DBM_DATA_W];
        data_lines_oe  <= 1'b1;
      end else if (state_reg inside {[DBM_ST_MWR2:DBM_ST_MWR4]}) begin
        data_lines_out <= temp_byte_reg;
        data_lines_oe  <= 1'b1;
      end else begin
        data_lines_out <= '0;
        data_lines_oe  <= 1'b0;
      end
    end
  end

  // Latch strobe on the falling edge so it settles mid-state
  always_ff @(negedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      upper_address_strobe <= 1'b0;
    end else if (ce) begin
      upper_address_strobe <= state_reg inside {DBM_ST_ADDR, DBM_ST_MRD1, DBM_ST_MWR1};
    end
  end

  // Acknowledge per channel; reset leaves all lines high, the idle level only when active low
  for (genvar a = 0; a < DBM_CHANNELS; a++) begin : g_ack
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        channel_acknowledge[a] <= 1'b1;
      end else if (ce) begin
        channel_acknowledge[a] <= (working && !m2m_reg && act_ch_reg == DBM_CH_W'(a)) ~^ ack_active_high;
      end
    end
  end

  // ****************************************************************
  // Completion events
  // ****************************************************************
  assign evt_push   = ce && (state_reg == DBM_ST_XFR4 || state_reg == DBM_ST_MWR4);
  assign evt_record = {work_ch, work_addr, count_reg[work_ch] == DBM_COUNT_LAST};

  // Mirror of the FIFO fill: a further byte starts only if its event will fit
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      evt_level_reg <= '0;
    end else if (ce) begin
      evt_level_reg <= evt_level_reg + EVT_LVL_W'(evt_push && evt_in_ready)
                       - EVT_LVL_W'(evt_valid && evt_ready);
    end
  end
  assign evt_room_next = evt_level_reg < EVT_LVL_W'(FIFO_DEPTH - 1);

  dbm_fifo #(
    .WIDTH (DBM_EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_evt_fifo (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .ce         (ce),
    .in_valid   (evt_push),
    .in_data    (evt_record),
    .in_ready   (evt_in_ready),
    .out_valid  (evt_valid),
    .out_data   (evt_data),
    .out_ready  (evt_ready)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n || !ce);

  AST_UPPER_HIZ: assert property (state_reg == DBM_ST_IDLE |=> !upper_nibble_address_oe)
    else $error("upper nibble driven while idle");
  AST_HOLD_REQ: assert property (state_reg == DBM_ST_IDLE && start_ok |-> ##2 bus_hold_request)
    else $error("hold request missing");
  AST_WAIT_GRANT: assert property (state_reg == DBM_ST_HOLD && !grant_sync_reg && !standalone_en
                                   |=> state_reg == DBM_ST_HOLD && !upper_address_enable)
    else $error("bus driven before grant");
  AST_ONE_WAIT: assert property (state_reg == DBM_ST_HOLD && standalone_en |=> state_reg != DBM_ST_HOLD)
    else $error("more than one hold-wait state");
  AST_ACK_IDLE: assert property (state_reg == DBM_ST_IDLE |=> channel_acknowledge == {4{~$past(ack_active_high)}})
    else $error("acknowledge not at inactive level");
  AST_AEN_WORK: assert property (state_reg == DBM_ST_XFR3 |=> upper_address_enable ##1 upper_address_enable)
    else $error("address enable dropped in transfer");
  AST_STROBE_CAUSE: assert property (upper_address_strobe
                                     |-> state_reg inside {DBM_ST_ADDR, DBM_ST_MRD1, DBM_ST_MWR1})
    else $error("address strobe without update state");
  AST_READ_STROBE: assert property (!memory_read_strobe_n
                                    |-> $past(state_reg) inside {DBM_ST_XFR3, DBM_ST_XFR4, DBM_ST_MRD2, DBM_ST_MRD3})
    else $error("read strobe outside read phase");
  AST_WRITE_STROBE: assert property (state_reg == DBM_ST_MWR3 |=> !memory_write_strobe_n ##1 !memory_write_strobe_n)
    else $error("write strobe missing in destination half");
  AST_IO_NO_CAPTURE: assert property (state_reg inside {[DBM_ST_ADDR:DBM_ST_XFR4]} |=> $stable(temp_byte_reg))
    else $error("data captured in I/O transfer");
  AST_TEMP_OUT: assert property (state_reg == DBM_ST_MWR3 |=> data_lines_oe && data_lines_out == temp_byte_reg)
    else $error("stored byte not driven");
  AST_M2M_LEN: assert property (state_reg == DBM_ST_MRD1 |-> ##7 state_reg == DBM_ST_MWR4)
    else $error("memory copy byte length wrong");
  AST_FILL_SRC: assert property (state_reg == DBM_ST_MRD4 && fill_en && !cfg_load
                                 |=> $stable(addr_reg[DBM_SRC_CH]))
    else $error("fill source moved");
  AST_PRIO0: assert property (state_reg == DBM_ST_IDLE && start_ok && pending[0] |=> act_ch_reg == 2'h0)
    else $error("channel 0 lost arbitration");
  AST_IDLE_RELEASE: assert property (state_reg == DBM_ST_IDLE
                                     |=> !upper_address_enable && !memory_read_strobe_oe && !data_lines_oe)
    else $error("bus held at idle");

  COV_M2M: cover property (state_reg == DBM_ST_MRD1 ##7 state_reg == DBM_ST_MWR4);
  COV_SKIP: cover property (state_reg == DBM_ST_XFR4 ##1 state_reg == DBM_ST_XFR2);
  COV_STANDALONE: cover property (state_reg == DBM_ST_HOLD && standalone_en ##1 state_reg == DBM_ST_ADDR);
  COV_FIFO_FULL: cover property (!evt_in_ready);

endmodule // dbm_top

// *** verification/dbm_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host arbiter and system memory stand-in
// ****************************************
module dbm_host_model #(
  parameter logic [7:0] MEM_BYTE = 8'h5a
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       bus_hold_request,
  output logic            bus_hold_grant,
  input  wire logic       memory_read_strobe_n,
  output logic [7:0]      data_lines_in
);
  logic [1:0] grant_dly_reg;
  logic [1:0] hold_reg;
  logic [7:0] junk_reg;
  // Slow host: grant two cycles after request, dropped with it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) grant_dly_reg <= 2'h0;
    else grant_dly_reg <= {grant_dly_reg[0] & bus_hold_request, bus_hold_request};
  end
  assign bus_hold_grant = grant_dly_reg[1] & bus_hold_request;
  // Memory keeps its byte two cycles past the strobe, then garbage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hold_reg <= 2'h0;
    else if (!memory_read_strobe_n) hold_reg <= 2'h2;
    else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
  end
  // Released bus flips every cycle so a stale capture shows
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) junk_reg <= 8'h00;
    else junk_reg <= ~junk_reg;
  end
  assign data_lines_in = (!memory_read_strobe_n || hold_reg != 2'h0) ? MEM_BYTE : junk_reg;
endmodule // dbm_host_model

// *** verification/dma_bus_master_signalling_test.sv ***
`timescale 1ns/1ps
module dma_bus_master_signalling_test;
  logic sys_clk, rst_n, ce, write_xfer, mem_to_mem_en, fill_en, ack_active_high, standalone_en, cfg_load;
  logic bus_hold_grant, evt_ready, bus_hold_request, upper_address_enable, upper_address_strobe, evt_valid;
  logic memory_read_strobe_n, memory_read_strobe_oe, memory_write_strobe_n, memory_write_strobe_oe;
  logic data_lines_oe, low_nibble_address_oe, upper_nibble_address_oe;
  logic [3:0] channel_request, channel_mask, sw_request, upper_nibble_address, low_nibble_address;
  logic [3:0] channel_acknowledge;
  logic [1:0] xfer_mode, cfg_channel;
  logic [15:0] cfg_addr, cfg_count;
  logic [7:0] data_lines_in, data_lines_out;
  logic [18:0] evt_data;
  int fail_count = 0;
  int compares = 0;
  dbm_top u_dut (.sys_clk, .rst_n, .ce, .channel_request, .channel_mask, .sw_request, .xfer_mode, .write_xfer,
    .mem_to_mem_en, .fill_en, .ack_active_high, .standalone_en, .cfg_load, .cfg_channel, .cfg_addr, .cfg_count,
    .bus_hold_grant, .bus_hold_request, .upper_nibble_address, .upper_nibble_address_oe, .low_nibble_address,
    .low_nibble_address_oe, .data_lines_in, .data_lines_out, .data_lines_oe, .upper_address_enable,
    .upper_address_strobe, .memory_read_strobe_n, .memory_read_strobe_oe, .memory_write_strobe_n,
    .memory_write_strobe_oe, .channel_acknowledge, .evt_valid, .evt_data, .evt_ready);
  dbm_host_model u_host (.sys_clk, .rst_n, .bus_hold_request, .bus_hold_grant, .memory_read_strobe_n,
    .data_lines_in);
  // ****************************************
  // Shared tasks
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [18:0] seen, input logic [18:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait: 0 acks, 1 hold request, 2 write strobe
  task wait_for(input int sel, input logic [3:0] v);
    int i;
    for (i = 0; i < 80; i++) begin
      if ((sel == 0 ? channel_acknowledge : sel == 1 ? {3'h0, bus_hold_request} :
           {3'h0, memory_write_strobe_n}) === v) break;
      @(negedge sys_clk);
    end
    if (i == 80) begin
      fail_count++;
      summarize();
    end
  endtask
  task load(input logic [1:0] ch, input logic [15:0] a, input logic [15:0] n);
    @(negedge sys_clk);
    {cfg_load, cfg_channel, cfg_addr, cfg_count} = {1'b1, ch, a, n};
    @(negedge sys_clk);
    cfg_load = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_masked();
    {channel_mask, channel_request} = 8'h11;
    repeat (12) @(negedge sys_clk);
    check(bus_hold_request, 8'h00);
    channel_request = 4'h0;
    repeat (3) @(negedge sys_clk);
    channel_mask = 4'h0;
  endtask
  // Two peripherals at once in demand mode; low channel wins, then the other
  task t_prio();
    evt_ready = 1'b0;
    xfer_mode = 2'h1;
    load(2'h2, 16'h12a7, 16'h0001);
    load(2'h1, 16'h34c5, 16'h0000);
    write_xfer = 1'b1;
    channel_request = 4'h6;
    wait_for(0, 4'hd);
    channel_request = 4'h4;
    check(upper_nibble_address, 8'h0c);
    check(low_nibble_address, 8'h05);
    check(upper_address_enable, 8'h01);
    check(memory_write_strobe_oe, 8'h01);
    check(data_lines_out, 8'h34);
    wait_for(2, 4'h0);
    check(memory_read_strobe_n, 8'h01);
    wait_for(0, 4'hb);
    channel_request = 4'h0;
    wait_for(1, 4'h0);
    @(negedge sys_clk);
    check(upper_address_enable, 8'h00);
    check(upper_nibble_address_oe, 8'h00);
    check(evt_data, 19'h2698b);
    evt_ready = 1'b1;
    @(negedge sys_clk);
    check(evt_data, 19'h4254e);
    @(negedge sys_clk);
    check(evt_valid, 8'h00);
  endtask
  // Block fill through the internal store, grant looped back
  task t_copy();
    {mem_to_mem_en, standalone_en, fill_en} = 3'h7;
    xfer_mode = 2'h2;
    load(2'h0, 16'h0100, 16'h0000);
    load(2'h1, 16'h0200, 16'h0001);
    sw_request = 4'h1;
    wait_for(2, 4'h0);
    sw_request = 4'h0;
    check(data_lines_out, 8'h5a);
    check(data_lines_oe, 8'h01);
    wait_for(2, 4'h1);
    wait_for(2, 4'h0);
    check(data_lines_out, 8'h5a);
    check(low_nibble_address, 8'h01);
    wait_for(1, 4'h0);
    {mem_to_mem_en, standalone_en, fill_en} = 3'h0;
  endtask
  initial begin
    {rst_n, ce, evt_ready, write_xfer, mem_to_mem_en, fill_en, ack_active_high, standalone_en} = 8'h60;
    {cfg_load, cfg_channel, cfg_addr, cfg_count, xfer_mode} = 0;
    {channel_request, channel_mask, sw_request} = 12'h000;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(channel_acknowledge, 8'h0f);
    check(upper_address_enable, 8'h00);
    t_masked();
    t_prio();
    t_copy();
    summarize();
  end
endmodule // dma_bus_master_signalling_test
